// ===== bench/srl_top_tb.sv
// srl_top_tb: self-checking bench for the set-reset latch control block
// assumes srl_pkg is compiled first and the bench is the only axi master
`timescale 1ns/1ns
`default_nettype none
module srl_top_tb;
	import srl_pkg::*;
	logic clk = 1'h0;
	logic rst_n = 1'h0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0, rdata;
	logic [3:0] wstrb = 4'hF;
	logic awv = 1'h0, wv = 1'h0, brdy = 1'h0, arv = 1'h0, rrdy = 1'h0;
	logic awrdy, wrdy, bv, arrdy, rv;
	logic [1:0] bresp, rresp;
	logic pin_in = 1'h0, cmp1 = 1'h0, cmp2 = 1'h0;
	srl_pins_type pins;
	logic [31:0] exp_q[$];
	logic [1:0] exp_r_q[$];
	int error_cnt = 0;
	int num_checks = 0;

	srl_top i_dut (.core_clk_i(clk), .arst_n_i(rst_n), .s_axi_awaddr_i(awaddr),
		.s_axi_awvalid_i(awv), .s_axi_awready_o(awrdy), .s_axi_wdata_i(wdata),
		.s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wv), .s_axi_wready_o(wrdy),
		.s_axi_bresp_o(bresp), .s_axi_bvalid_o(bv), .s_axi_bready_i(brdy),
		.s_axi_araddr_i(araddr), .s_axi_arvalid_i(arv), .s_axi_arready_o(arrdy),
		.s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rv),
		.s_axi_rready_i(rrdy), .latch_input_pin_i(pin_in), .cmp1_out_i(cmp1),
		.cmp2_out_i(cmp2), .pins_o(pins));

	// 10 MHz core clock
	initial forever #50 clk = ~clk;

	task automatic check(input string nm, input logic [31:0] e, input logic [31:0] s);
		num_checks++;
		if (s !== e) begin
			$display("mismatch %s expected %h seen %h", nm, e, s);
			error_cnt++;
		end
	endtask

	task automatic finish_test();
		if (error_cnt == 0 && num_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// handshakes sampled at the falling edge, released right after the taking edge
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
		input logic [1:0] er);
		logic ha, hw, hb;
		int t;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awv <= 1'h1;
		wv <= 1'h1;
		brdy <= 1'h1;
		t = 0;
		do begin
			@(negedge clk);
			ha = awv && awrdy;
			hw = wv && wrdy;
			hb = brdy && bv;
			if (hb) check("bresp", {30'h0, er}, {30'h0, bresp});
			@(posedge clk);
			if (ha) awv <= 1'h0;
			if (hw) wv <= 1'h0;
			if (hb) brdy <= 1'h0;
			t++;
		end while (!hb && t < 50);
		if (!hb) check("write answer", 32'h1, 32'h0);
	endtask

	// the expected word is noted before the request goes out
	task automatic rd(input logic [7:0] a, input logic [31:0] e,
		input logic [1:0] er = SRL_RESP_OKAY);
		logic ha, hr;
		int t;
		@(posedge clk);
		exp_q.push_back(e);
		exp_r_q.push_back(er);
		araddr <= a;
		arv <= 1'h1;
		rrdy <= 1'h1;
		t = 0;
		do begin
			@(negedge clk);
			ha = arv && arrdy;
			hr = rrdy && rv;
			@(posedge clk);
			if (ha) arv <= 1'h0;
			if (hr) rrdy <= 1'h0;
			t++;
		end while (!hr && t < 50);
		if (!hr) check("read answer", 32'h1, 32'h0);
	endtask

	// pins settle up to two cycles after the register update
	task automatic pchk(input logic [3:0] e);
		repeat (2) @(posedge clk);
		@(negedge clk);
		check("pins", {28'h0, e}, {28'h0, pins});
		@(posedge clk);
	endtask

	// cmp1 holds set high, divider pulses reset: true_out dips once per period
	task automatic div_chk(input int c);
		int n, t0, k;
		logic p;
		wr(SRL_CTRL0_OFS, 32'h88 | (c << 4), 4'hF, SRL_RESP_OKAY);
		k = 0;
		n = 0;
		t0 = 0;
		p = 1'h0;
		while (k < 3 && n < 2000) begin
			@(negedge clk);
			n++;
			if (k > 0 && p === 1'h0) check("dip width", 32'h1, {31'h0, pins.true_out});
			if (p === 1'h1 && pins.true_out === 1'h0) begin
				if (k > 0) check("divider period", 32'h1 << (c + 2), n - t0);
				t0 = n;
				k++;
			end
			p = pins.true_out;
		end
		if (k < 3) check("divider pulses", 32'h3, k);
		@(posedge clk);
	endtask

	// read scoreboard: oldest note against each accepted read beat
	always @(posedge clk) begin
		if (rv === 1'h1 && rrdy === 1'h1) begin
			if (exp_q.size() == 0) begin
				check("unexpected rdata", 32'h0, 32'h1);
			end else begin
				check("rresp", {30'h0, exp_r_q.pop_front()}, {30'h0, rresp});
				check("rdata", exp_q.pop_front(), rdata);
			end
		end
	end

	// watchdog well above the roughly 3000 cycles the tests need
	initial begin
		#4000000;
		error_cnt++;
		finish_test();
	end

	initial begin : main
		logic [31:0] rnd;
		void'($urandom(31734));
		rnd = $urandom;
		pin_in <= rnd[0];
		cmp2 <= rnd[1];
		repeat (3) @(posedge clk);
		rst_n <= 1'h1;
		@(posedge clk);
		wr(SRL_CTRL0_OFS, 32'h01, 4'hF, SRL_RESP_OKAY);
		rd(SRL_CTRL0_OFS, {24'h0, SRL_CTRL0_RST});
		rd(SRL_SRCSEL_OFS, {24'h0, SRL_SRCSEL_RST});
		wr(SRL_SRCSEL_OFS, rnd, 4'hF, SRL_RESP_OKAY);
		rd(SRL_SRCSEL_OFS, {24'h0, rnd[7:0]});
		wr(SRL_SRCSEL_OFS, 32'h0, 4'hF, SRL_RESP_OKAY);
		wr(SRL_CTRL0_OFS, {rnd[31:8], 8'h8D}, 4'hF, SRL_RESP_OKAY);
		pchk(4'h7);
		rd(SRL_STAT_OFS, 32'h0);
		wr(SRL_CTRL0_OFS, 32'h8E, 4'hF, SRL_RESP_OKAY);
		pchk(4'hD);
		rd(SRL_CTRL0_OFS, 32'h8C);
		rd(SRL_STAT_OFS, 32'h1);
		// a write without byte 0 strobe must not pulse reset
		wr(SRL_CTRL0_OFS, 32'h8D, 4'h0, SRL_RESP_OKAY);
		pchk(4'hD);
		wr(SRL_CTRL0_OFS, 32'h8F, 4'hF, SRL_RESP_OKAY);
		pchk(4'h7);
		wr(SRL_CTRL0_OFS, 32'h84, 4'hF, SRL_RESP_OKAY);
		pchk(4'h3);
		wr(SRL_CTRL0_OFS, 32'h0C, 4'hF, SRL_RESP_OKAY);
		pchk(4'h0);
		wr(8'h0C, 32'hFF, 4'hF, SRL_RESP_SLVERR);
		rd(8'h0C, 32'h0, SRL_RESP_SLVERR);
		rd(SRL_CTRL0_OFS, 32'h0C);
		cmp1 <= 1'h1;
		wr(SRL_SRCSEL_OFS, 32'h14, 4'hF, SRL_RESP_OKAY);
		for (int c = 0; c < 8; c++) div_chk(c);
		finish_test();
	end
endmodule // srl_top_tb
`default_nettype wire

// ===== verilog/srl_pkg.sv
// srl_pkg: constants, register map and carrier types of the set-reset latch control
// assumes a 32-bit axi4-lite master and one 10 MHz core clock
// Functional notes
// - bit 7 enables or disables the latch
// - divider code picks pulse every 4..512 clocks
// - enabled with true enable drives true pin
// - true enable clear hides true output
// - enabled with inverted enable drives inverted pin
// - writing one pulses set for one clock
// - writing one pulses reset for one clock
// - set and reset pulse bits read zero
// - reset wins when set and reset high
// - enable bits route sources to set, reset
// - latch state after reset is undefined
`default_nettype none
package srl_pkg;
	localparam logic [7:0] SRL_CTRL0_OFS = 8'h00; // latch_control_zero
	localparam logic [7:0] SRL_SRCSEL_OFS = 8'h04; // latch_source_select
	localparam logic [7:0] SRL_STAT_OFS = 8'h08; // latch state readback
	localparam logic [7:0] SRL_CTRL0_RST = 8'h00;
	localparam logic [7:0] SRL_SRCSEL_RST = 8'h00;
	localparam int SRL_EN_BIT = 7;
	localparam int SRL_DIV_LSB = 4;
	localparam int SRL_QEN_BIT = 3;
	localparam int SRL_NQEN_BIT = 2;
	localparam int SRL_PSET_BIT = 1;
	localparam int SRL_PRST_BIT = 0;
	localparam int SRL_DIV_MIN_LOG2 = 2; // code 000 divides by 4
	localparam logic [1:0] SRL_RESP_OKAY = 2'b00;
	localparam logic [1:0] SRL_RESP_SLVERR = 2'b10;
	localparam int SRL_DIVCNT_W = 9;

	// latch source inputs, already in the core clock domain
	typedef struct packed {
		logic pin;
		logic clk_pulse;
		logic cmp2;
		logic cmp1;
	} srl_src_type;

	// latch pins with output enables
	typedef struct packed {
		logic true_out;
		logic true_oe;
		logic inv_out;
		logic inv_oe;
	} srl_pins_type;
endpackage : srl_pkg
`default_nettype wire

// ===== verilog/srl_top.sv
// srl_top: set-reset latch with control registers behind an axi4-lite slave
// assumes comparator inputs are synchronous to core_clk_i; the pin input is not
//
// Decided for this implementation: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module srl_top (
	input wire logic core_clk_i, // 10 MHz core clock
	input wire logic arst_n_i, // async reset, active low
	input wire logic [7:0] s_axi_awaddr_i, // write address
	input wire logic s_axi_awvalid_i, // write address valid
	output logic s_axi_awready_o, // write address ready
	input wire logic [31:0] s_axi_wdata_i, // write data
	input wire logic [3:0] s_axi_wstrb_i, // write strobes
	input wire logic s_axi_wvalid_i, // write data valid
	output logic s_axi_wready_o, // write data ready
	output logic [1:0] s_axi_bresp_o, // write response
	output logic s_axi_bvalid_o, // write response valid
	input wire logic s_axi_bready_i, // write response ready
	input wire logic [7:0] s_axi_araddr_i, // read address
	input wire logic s_axi_arvalid_i, // read address valid
	output logic s_axi_arready_o, // read address ready
	output logic [31:0] s_axi_rdata_o, // read data
	output logic [1:0] s_axi_rresp_o, // read response
	output logic s_axi_rvalid_o, // read data valid
	input wire logic s_axi_rready_i, // read data ready
	input wire logic latch_input_pin_i, // external latch input pin
	input wire logic cmp1_out_i, // comparator 1 output, synchronous
	input wire logic cmp2_out_i, // comparator 2 output, synchronous
	output srl_pkg::srl_pins_type pins_o // true and inverted pins with enables
);
	import srl_pkg::*;

	logic [7:0] ctrl_r;
	logic [7:0] srcsel_r;
	logic pset_r;
	logic prst_r;
	logic [1:0] pin_sync_r;
	logic [SRL_DIVCNT_W-1:0] div_cnt_r;
	logic div_pulse;
	logic latch_q_r;
	logic set_in;
	logic rst_in;
	srl_src_type src;
	logic aw_held_r;
	logic w_held_r;
	logic [7:0] awaddr_r;
	logic [31:0] wdata_r;
	logic [3:0] wstrb_r;
	logic wr_fire;
	logic latch_en;
	logic [7:0] rd_byte;
	logic rd_hit;

	// pin passes two flops before the latch sees it
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			pin_sync_r <= 2'h0;
		end else begin
			pin_sync_r <= {pin_sync_r[0], latch_input_pin_i};
		end
	end

	assign latch_en = ctrl_r[SRL_EN_BIT];

	// free-running divider, pulse when the selected low bits are all one
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			div_cnt_r <= '0;
		end else begin
			div_cnt_r <= div_cnt_r + 1'b1;
		end
	end

	// mask width is code plus two, giving period 4 to 512
	function automatic logic div_hit(input logic [SRL_DIVCNT_W-1:0] cnt, input logic [2:0] code);
		logic [SRL_DIVCNT_W-1:0] mask;
		mask = SRL_DIVCNT_W'((10'h001 << (int'(code) + SRL_DIV_MIN_LOG2)) - 10'h001);
		return (cnt & mask) == mask;
	endfunction

	assign div_pulse = div_hit(div_cnt_r, ctrl_r[SRL_DIV_LSB +: 3]);

	// per-source enables for set (upper nibble) and reset (lower nibble)
	assign src = '{pin: pin_sync_r[1], clk_pulse: div_pulse, cmp2: cmp2_out_i, cmp1: cmp1_out_i};
	assign set_in = pset_r | |(srcsel_r[7:4] & src);
	assign rst_in = prst_r | |(srcsel_r[3:0] & src);

	// latch state is not reset; firmware initialises it
	always_ff @(posedge core_clk_i) begin
		if (rst_in) begin
			latch_q_r <= 1'b0;
		end else if (set_in) begin
			latch_q_r <= 1'b1;
		end
	end

	// outputs only while latch enabled and each enable set
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			pins_o <= '0;
		end else begin
			pins_o.true_oe <= latch_en & ctrl_r[SRL_QEN_BIT];
			pins_o.true_out <= latch_en & ctrl_r[SRL_QEN_BIT] & latch_q_r;
			pins_o.inv_oe <= latch_en & ctrl_r[SRL_NQEN_BIT];
			pins_o.inv_out <= latch_en & ctrl_r[SRL_NQEN_BIT] & ~latch_q_r;
		end
	end

	// write channel: address and data caught in either order
	assign s_axi_awready_o = ~aw_held_r & ~s_axi_bvalid_o;
	assign s_axi_wready_o = ~w_held_r & ~s_axi_bvalid_o;
	assign wr_fire = aw_held_r & w_held_r & ~s_axi_bvalid_o;

	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			aw_held_r <= 1'b0;
			w_held_r <= 1'b0;
			awaddr_r <= 8'h00;
			wdata_r <= 32'h0000_0000;
			wstrb_r <= 4'h0;
		end else begin
			if (s_axi_awvalid_i && s_axi_awready_o) begin
				aw_held_r <= 1'b1;
				awaddr_r <= s_axi_awaddr_i;
			end else if (wr_fire) begin
				aw_held_r <= 1'b0;
			end
			if (s_axi_wvalid_i && s_axi_wready_o) begin
				w_held_r <= 1'b1;
				wdata_r <= s_axi_wdata_i;
				wstrb_r <= s_axi_wstrb_i;
			end else if (wr_fire) begin
				w_held_r <= 1'b0;
			end
		end
	end

	// write response one cycle after both halves are held
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			s_axi_bvalid_o <= 1'b0;
			s_axi_bresp_o <= SRL_RESP_OKAY;
		end else if (wr_fire) begin
			s_axi_bvalid_o <= 1'b1;
			s_axi_bresp_o <= (awaddr_r[7:2] == SRL_CTRL0_OFS[7:2] ||
				awaddr_r[7:2] == SRL_SRCSEL_OFS[7:2] ||
				awaddr_r[7:2] == SRL_STAT_OFS[7:2]) ? SRL_RESP_OKAY : SRL_RESP_SLVERR;
		end else if (s_axi_bready_i) begin
			s_axi_bvalid_o <= 1'b0;
		end
	end

	// control registers; pulse bits never stored in ctrl_r
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ctrl_r <= SRL_CTRL0_RST;
			srcsel_r <= SRL_SRCSEL_RST;
		end else if (wr_fire && wstrb_r[0]) begin
			if (awaddr_r[7:2] == SRL_CTRL0_OFS[7:2]) begin
				ctrl_r <= {wdata_r[7:2], 2'b00};
			end
			if (awaddr_r[7:2] == SRL_SRCSEL_OFS[7:2]) begin
				srcsel_r <= wdata_r[7:0];
			end
		end
	end

	// self-clearing pulses, one core clock wide
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			pset_r <= 1'b0;
			prst_r <= 1'b0;
		end else begin
			pset_r <= wr_fire & wstrb_r[0] & (awaddr_r[7:2] == SRL_CTRL0_OFS[7:2]) &
				wdata_r[SRL_PSET_BIT];
			prst_r <= wr_fire & wstrb_r[0] & (awaddr_r[7:2] == SRL_CTRL0_OFS[7:2]) &
				wdata_r[SRL_PRST_BIT];
		end
	end

	// read mux; pulse bits read zero since ctrl_r never holds them
	always_comb begin
		rd_hit = 1'b1;
		rd_byte = 8'h00;
		case (s_axi_araddr_i[7:2])
			SRL_CTRL0_OFS[7:2]: rd_byte = ctrl_r;
			SRL_SRCSEL_OFS[7:2]: rd_byte = srcsel_r;
			SRL_STAT_OFS[7:2]: rd_byte = {7'h00, latch_q_r};
			default: rd_hit = 1'b0;
		endcase
	end

	assign s_axi_arready_o = ~s_axi_rvalid_o;

	// read answer one cycle after the address is taken
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			s_axi_rvalid_o <= 1'b0;
			s_axi_rdata_o <= 32'h0000_0000;
			s_axi_rresp_o <= SRL_RESP_OKAY;
		end else if (s_axi_arvalid_i && s_axi_arready_o) begin
			s_axi_rvalid_o <= 1'b1;
			s_axi_rdata_o <= {24'h000000, rd_byte};
			s_axi_rresp_o <= rd_hit ? SRL_RESP_OKAY : SRL_RESP_SLVERR;
		end else if (s_axi_rready_i) begin
			s_axi_rvalid_o <= 1'b0;
		end
	end

	// checks beside the logic; latch state is unknown until firmware sets or clears it

	a_reset_dominant: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
		rst_in |=> !latch_q_r) else $error("reset input did not clear latch");

	a_set_takes: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
		set_in && !rst_in |=> latch_q_r) else $error("set input did not set latch");

	a_pulse_width: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
		pset_r |=> !pset_r) else $error("set pulse longer than one clock");

	a_rpulse_width: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
		$rose(prst_r) |=> !prst_r) else $error("reset pulse longer than one clock");

	// pulse bits of control read zero
	a_pulse_read_zero: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
		$rose(s_axi_rvalid_o) && $past(s_axi_araddr_i[7:2]) == SRL_CTRL0_OFS[7:2] |->
		s_axi_rdata_o[1:0] == 2'b00) else $error("pulse bits read back nonzero");

	a_true_hidden: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
		!ctrl_r[SRL_QEN_BIT] |=> !pins_o.true_oe && !pins_o.true_out)
		else $error("true output shown while disabled");

	a_true_drive: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
		latch_en && ctrl_r[SRL_QEN_BIT] |=> pins_o.true_oe && pins_o.true_out == $past(latch_q_r))
		else $error("true pin does not follow latch");

	a_inv_drive: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
		latch_en && ctrl_r[SRL_NQEN_BIT] |=> pins_o.inv_oe && pins_o.inv_out == !$past(latch_q_r))
		else $error("inverted pin does not follow latch");

	a_disable_all: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
		!latch_en |=> !pins_o.true_oe && !pins_o.inv_oe) else $error("pins enabled while off");

	// code 000 gives period four while the code stays
	a_div_period: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
		div_pulse && ctrl_r[6:4] == 3'h0 && $stable(ctrl_r) |=>
		!div_pulse [*3] ##1 (div_pulse || ctrl_r[6:4] != 3'h0))
		else $error("divider period wrong for code 000");

	a_src_route: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
		srcsel_r[4] && cmp1_out_i |-> set_in) else $error("comparator 1 not routed to set");

	a_cmp2_route: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
		srcsel_r[1] && cmp2_out_i |-> rst_in) else $error("comparator 2 not routed to reset");

	a_pin_route: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
		srcsel_r[3] && pin_sync_r[1] |-> rst_in) else $error("pin not routed to reset");

	a_div_route: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
		srcsel_r[6] && div_pulse |-> set_in) else $error("divider not routed to set");

	a_no_source: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
		!pset_r && srcsel_r[7:4] == 4'h0 |-> !set_in) else $error("set without a source");

	a_pset_drive: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
		pset_r |-> set_in) else $error("set pulse not on set input");

	a_prst_drive: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
		prst_r |-> rst_in) else $error("reset pulse not on reset input");

	a_inv_hidden: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
		!ctrl_r[SRL_NQEN_BIT] |=> !pins_o.inv_oe && !pins_o.inv_out)
		else $error("inverted output shown while disabled");

	// write answer stands until taken
	a_bvalid_hold: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
		s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
		else $error("write response dropped early");

	// read answer stands until taken
	a_rvalid_hold: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
		s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
		else $error("read data dropped early");
endmodule // srl_top
`default_nettype wire
